// ==== verilog/vcxb_engine.sv ====
// External buffer transfer engine: channel buffers, descriptor sequence, errors
//
// Operation
// - Push channel writes whole internal buffer in one sized write burst
// - Pull channel refills internal buffer with one sized read burst
// - Skip data burst when descriptor shows buffer unavailable
// - Write back only descriptor second dword, one single-dword write
// - Write-back changes only status code, wrap toggle and offset pointer
// - Every channel tracks its own position and full or empty state
// - Full or empty buffer enqueues channel and sets its pending bit
// - Queue entries run the sequence; pending bit clears when it ends
// - Eight error bits at 0x126, each driving a maskable interrupt input
// - Bit 7 on abnormal end of an engine PCI cycle
// - Bit 6 when fetched descriptor shows buffer locked
// - Bit 5 and access denied on pointer boundary
// - Bit 4 when one access remains before a boundary
// - Bit 3 when overwrite enabled, push channels only
// - Bit 2 when agent has written nothing yet, pull initial state
// - Bit 1 when channel size is out of range or exceeds buffer space
// - Bit 0 when a queued request waits beyond one frame
// - Sequence starts with two-dword descriptor read at base plus offset
// - Status code encoding shared by engine and agent
// - Wrap toggle inverts when offset pointer rolls over
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module vcxb_engine
    import vcxb_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            reset_n_i,
    input  wire logic [19:0]     reg_addr_i,
    input  wire logic [31:0]     reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic [31:0]          reg_rdata_o,
    input  wire logic            tdm_valid_i,
    input  wire logic [CH_W-1:0] tdm_ch_i,
    input  wire logic [31:0]     tdm_wdata_i,
    output logic [31:0]          tdm_rdata_o,
    output vcxb_pci_req_t        pci_req_o,
    output logic [31:0]          pci_wdata_o,
    input  wire vcxb_pci_rsp_t   pci_rsp_i,
    output logic [7:0]           sys_err_o
);
    function automatic logic [MEM_W-1:0] buf_addr(input logic [MEM_W-1:0] base,
                                                  input logic [6:0] idx);
        buf_addr = base + MEM_W'(idx);
    endfunction

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0]       buf_mem [MEM_DW];
    logic [6:0]        ch_size [NUM_CH];
    logic [MEM_W-1:0]  ch_base [NUM_CH];
    logic [6:0]        ch_pos  [NUM_CH];
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0] ch_pull;

    logic [31:0]     desc_base;
    logic [CH_W-1:0] ch_sel;
    logic [7:0]      sys_err;
    vcxb_state_t     state;
    logic [CH_W-1:0] cur_ch;
    logic [31:0]     d0;
    logic [31:0]     d1;
    logic [6:0]      beat_idx;
    logic            fetch_beat;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire         wr_base = reg_wr_i && (reg_addr_i == DESC_BASE_OFS);
    wire         wr_clr  = reg_wr_i && (reg_addr_i == ERR_CLR_OFS);
    wire         wr_sel  = reg_wr_i && (reg_addr_i == CH_SEL_OFS);
    wire         wr_cfg  = reg_wr_i && (reg_addr_i == CH_CFG_OFS);
    wire [6:0]   cfg_sz  = reg_wdata_i[CFG_SZ +: 7];
    wire [MEM_W-1:0] cfg_base = reg_wdata_i[CFG_BASE +: MEM_W];
    wire         cfg_bad = (cfg_sz < MIN_BUF_DW) || (cfg_sz > MAX_BUF_DW)
                        || ({1'b0, cfg_base} + (MEM_W+1)'(cfg_sz) > (MEM_W+1)'(MEM_DW));
    wire [31:0]  cfg_rd  = {6'h00, ch_pos[ch_sel], ch_base[ch_sel],
                            ch_size[ch_sel], ch_pull[ch_sel], ch_en[ch_sel]};
    wire [31:0]  stat_rd = {22'h000000, cur_ch, (state != ST_IDLE)};
    logic [31:0] rd_val;
    always_comb begin
        if (reg_addr_i == DESC_BASE_OFS) rd_val = desc_base;
        else if (reg_addr_i == SYS_ERR_OFS) rd_val = {24'h000000, sys_err};
        else if (reg_addr_i == CH_SEL_OFS) rd_val = {23'h000000, ch_sel};
        else if (reg_addr_i == CH_CFG_OFS) rd_val = cfg_rd;
        else if (reg_addr_i == ENG_STAT_OFS) rd_val = stat_rd;
        else rd_val = 32'h0000_0000;
    end

    // ****************************************************************
    // Channel side: position tracking and notify
    // ****************************************************************
    wire             tdm_go   = tdm_valid_i && ch_en[tdm_ch_i];
    wire [6:0]       tdm_pos  = ch_pos[tdm_ch_i];
    wire [MEM_W-1:0] tdm_addr = buf_addr(ch_base[tdm_ch_i], tdm_pos);
    wire             tdm_last = (tdm_pos + 7'h01 == ch_size[tdm_ch_i]);
    wire             q_head_valid;
    wire [CH_W-1:0]  q_head_ch;
    wire             q_dup;
    wire             q_stale;
    wire             seq_end;
    wire             start    = (state == ST_IDLE) && q_head_valid;

    vcxb_notify_queue u_queue (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .push_i       (tdm_go && tdm_last),
        .push_ch_i    (tdm_ch_i),
        .pop_i        (start),
        .clear_i      (seq_end),
        .clear_ch_i   (cur_ch),
        .head_valid_o (q_head_valid),
        .head_ch_o    (q_head_ch),
        .dup_o        (q_dup),
        .stale_o      (q_stale)
    );

    // ****************************************************************
    // Descriptor decode
    // ****************************************************************
    wire        is_pull = ch_pull[cur_ch];
    wire [6:0]  cur_sz  = ch_size[cur_ch];
    wire [11:0] xbytes  = {3'h0, cur_sz, 2'h0};
    wire [11:0] last    = d0[11:0];
    // Second dword may land together with done, so decode it as it arrives
    wire [31:0] dsc     = (state == ST_FETCH && pci_rsp_i.beat && fetch_beat)
                        ? pci_rsp_i.rdata : d1;
    wire [11:0] engine_offset_pointer     = dsc[D_TOR +: 12];
    wire [11:0] agent_offset_pointer     = dsc[D_UOR +: 12];
    wire [2:0]  buffer_status_code     = dsc[D_GBS +: 3];
    wire        lap_eq  = (dsc[D_TF] == dsc[D_UF]);
    wire [11:0] gap     = agent_offset_pointer - engine_offset_pointer;
    wire [12:0] sum     = {1'b0, engine_offset_pointer} + {1'b0, xbytes};
    wire        locked  = dsc[D_LK] || (buffer_status_code == GBS_OFF);
    wire        full    = !lap_eq && (gap == 12'h000);
    wire        empty   = lap_eq && (gap == 12'h000);
    wire        ovwr    = !is_pull && full && dsc[D_OE];
    wire        pstall  = is_pull ? empty : (full && !dsc[D_OE]);
    wire        estall  = dsc[D_SE] && (engine_offset_pointer > last);
    wire        stall   = pstall || estall;
    wire        deny    = locked || stall;
    wire        imm     = ((is_pull == lap_eq) && (gap == xbytes))
                       || (dsc[D_SE] && (sum > {1'b0, last}));
    wire        initial_st = is_pull && empty && (agent_offset_pointer == 12'h000);
    // Without stop enable the pointer rolls over past the last offset
    wire        wrap    = !dsc[D_SE] && (sum > {1'b0, last});
    wire [11:0] tor_n   = deny ? engine_offset_pointer : (wrap ? 12'h000 : sum[11:0]);
    wire        tf_n    = dsc[D_TF] ^ (wrap && !deny);
    wire [2:0]  gbs_n   = locked ? ((buffer_status_code == GBS_OFF) ? GBS_OFF : GBS_LOCKED)
                        : stall ? GBS_STALL : ovwr ? GBS_OVWR
                        : imm ? GBS_BOUND : GBS_NORMAL;
    wire [31:0] d1_n    = {dsc[31:16], gbs_n, tf_n, tor_n};
    wire [31:0] desc_addr = desc_base + {20'h00000, cur_ch, 3'h0};
    wire        fetch_ok  = (state == ST_FETCH) && pci_rsp_i.done && !pci_rsp_i.err;
    wire [MEM_W-1:0] eng_addr = buf_addr(ch_base[cur_ch], beat_idx);
    assign seq_end = (pci_rsp_i.done && (state == ST_UPDATE))
                  || ((state != ST_IDLE) && pci_rsp_i.err);

    wire [7:0] err_set;
    assign err_set[ERR_FATAL] = (state != ST_IDLE) && pci_rsp_i.err;
    assign err_set[ERR_LOCK]  = fetch_ok && locked;
    assign err_set[ERR_STALL] = fetch_ok && !locked && stall;
    assign err_set[ERR_IMM]   = fetch_ok && !deny && imm;
    assign err_set[ERR_OVWR]  = fetch_ok && !is_pull && dsc[D_OE];
    assign err_set[ERR_INIT]  = fetch_ok && initial_st;
    assign err_set[ERR_SPAD]  = wr_cfg && cfg_bad;
    assign err_set[ERR_NQ]    = q_stale || q_dup;

    // ****************************************************************
    // Memories
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (tdm_go && !ch_pull[tdm_ch_i]) begin
            buf_mem[tdm_addr] <= tdm_wdata_i;
        end
        if (state == ST_DATA && is_pull && pci_rsp_i.beat) begin
            buf_mem[eng_addr] <= pci_rsp_i.rdata;
        end
        if (wr_cfg) begin
            ch_size[ch_sel] <= cfg_sz;
            ch_base[ch_sel] <= cfg_base;
            ch_pos[ch_sel]  <= 7'h00;
        end else if (tdm_go) begin
            ch_pos[tdm_ch_i] <= tdm_last ? 7'h00 : tdm_pos + 7'h01;
        end
    end

    // ****************************************************************
    // Registers and sequencer
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            desc_base   <= DESC_BASE_RST;
            ch_sel      <= '0;
            ch_en       <= '0;
            ch_pull     <= '0;
            sys_err     <= SYS_ERR_RST;
            sys_err_o   <= SYS_ERR_RST;
            reg_rdata_o <= 32'h0000_0000;
            tdm_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_val : 32'h0000_0000;
            if (wr_base) desc_base <= reg_wdata_i;
            if (wr_sel) ch_sel <= reg_wdata_i[CH_W-1:0];
            if (wr_cfg) begin
                ch_en[ch_sel]   <= reg_wdata_i[CFG_EN];
                ch_pull[ch_sel] <= reg_wdata_i[CFG_PULL];
            end
            // Sticky until written one, and a new event beats the clear
            sys_err   <= (sys_err & ~(wr_clr ? reg_wdata_i[7:0] : 8'h00)) | err_set;
            sys_err_o <= sys_err;
            if (tdm_go && ch_pull[tdm_ch_i]) tdm_rdata_o <= buf_mem[tdm_addr];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state       <= ST_IDLE;
            cur_ch      <= '0;
            d0          <= 32'h0000_0000;
            d1          <= 32'h0000_0000;
            beat_idx    <= 7'h00;
            fetch_beat  <= 1'b0;
            pci_req_o   <= '0;
            pci_wdata_o <= 32'h0000_0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        cur_ch     <= q_head_ch;
                        fetch_beat <= 1'b0;
                        state      <= ST_FETCH;
                        pci_req_o  <= '{1'b1, 1'b0,
                                       desc_base + {20'h00000, q_head_ch, 3'h0}, 7'h02};
                    end
                end
                ST_FETCH: begin
                    if (pci_rsp_i.beat) begin
                        fetch_beat <= 1'b1;
                        if (fetch_beat) d1 <= pci_rsp_i.rdata;
                        else d0 <= pci_rsp_i.rdata;
                    end
                    if (pci_rsp_i.err) begin
                        pci_req_o <= '0;
                        state     <= ST_IDLE;
                    end else if (pci_rsp_i.done && deny) begin
                        pci_req_o   <= '{1'b1, 1'b1, desc_addr + 32'h4, 7'h01};
                        pci_wdata_o <= d1_n;
                        state       <= ST_UPDATE;
                    end else if (pci_rsp_i.done) begin
                        beat_idx    <= 7'h00;
                        pci_req_o   <= '{1'b1, !is_pull, {d0[31:12], engine_offset_pointer}, cur_sz};
                        pci_wdata_o <= buf_mem[buf_addr(ch_base[cur_ch], 7'h00)];
                        state       <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (pci_rsp_i.beat) begin
                        beat_idx    <= beat_idx + 7'h01;
                        pci_wdata_o <= buf_mem[buf_addr(ch_base[cur_ch], beat_idx + 7'h01)];
                    end
                    if (pci_rsp_i.err) begin
                        pci_req_o <= '0;
                        state     <= ST_IDLE;
                    end else if (pci_rsp_i.done) begin
                        pci_req_o   <= '{1'b1, 1'b1, desc_addr + 32'h4, 7'h01};
                        pci_wdata_o <= d1_n;
                        state       <= ST_UPDATE;
                    end
                end
                ST_UPDATE: begin
                    if (pci_rsp_i.done) begin
                        pci_req_o <= '0;
                        state     <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_fetch_two_dw: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        start |=> pci_req_o.valid && !pci_req_o.write && pci_req_o.len == 7'h02
                  && pci_req_o.addr == desc_base + {20'h00000, cur_ch, 3'h0})
        else $error("descriptor fetch malformed");
    a_skip_denied: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (fetch_ok && deny) |=> state == ST_UPDATE) else $error("data burst not skipped");
    a_data_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (fetch_ok && !deny) |=> pci_req_o.len == $past(cur_sz) && pci_req_o.write == !$past(is_pull))
        else $error("data burst not sized to buffer");
    a_update_one_dw: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state == ST_UPDATE) |-> pci_req_o.write && pci_req_o.len == 7'h01
                  && pci_req_o.addr == desc_addr + 32'h4) else $error("update not one dword");
    a_update_keep: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state == ST_UPDATE) |-> pci_wdata_o[31:16] == d1[31:16])
        else $error("write-back altered agent fields");
    a_fatal_bit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state != ST_IDLE && pci_rsp_i.err) |=> sys_err[ERR_FATAL] ##1 sys_err_o[ERR_FATAL])
        else $error("fatal bit missing");
    a_lock_bit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (fetch_ok && locked) |=> sys_err[ERR_LOCK] && pci_wdata_o[15:13] != GBS_NORMAL)
        else $error("lock bit missing");
    a_err_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (sys_err[ERR_STALL] && !wr_clr) |=> sys_err[ERR_STALL])
        else $error("error bit lost without clear");
    a_wrap_toggle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (fetch_ok && !deny && wrap) |=> ##[1:300] (state == ST_UPDATE
                  && pci_wdata_o[D_TF] != d1[D_TF] && pci_wdata_o[11:0] == 12'h000))
        else $error("wrap toggle not inverted");
endmodule

// ==== verilog/vcxb_pkg.sv ====
// Shared constants and carrier types for the external buffer transfer engine
package vcxb_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [19:0] DESC_BASE_OFS = 20'h00110;
    localparam logic [19:0] SYS_ERR_OFS   = 20'h00126;
    localparam logic [19:0] ERR_CLR_OFS   = 20'h00130;
    localparam logic [19:0] CH_SEL_OFS    = 20'h00134;
    localparam logic [19:0] CH_CFG_OFS    = 20'h00138;
    localparam logic [19:0] ENG_STAT_OFS  = 20'h0013C;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int          CH_W          = 9;
    localparam int          NUM_CH        = 512;
    localparam int          MEM_W         = 10;
    localparam int          MEM_DW        = 1024;
    localparam logic [6:0]  MIN_BUF_DW    = 7'h02;
    localparam logic [6:0]  MAX_BUF_DW    = 7'h40;
    localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;
    localparam logic [7:0]  SYS_ERR_RST   = 8'h00;

    // Channel config word: enable, pull, size in dwords, buffer base dword
    localparam int CFG_EN   = 0;
    localparam int CFG_PULL = 1;
    localparam int CFG_SZ   = 2;
    localparam int CFG_BASE = 9;

    // System error bit positions
    localparam int ERR_FATAL = 7;
    localparam int ERR_LOCK  = 6;
    localparam int ERR_STALL = 5;
    localparam int ERR_IMM   = 4;
    localparam int ERR_OVWR  = 3;
    localparam int ERR_INIT  = 2;
    localparam int ERR_SPAD  = 1;
    localparam int ERR_NQ    = 0;

    // Descriptor second dword layout
    localparam int D_SE  = 31;
    localparam int D_OE  = 30;
    localparam int D_LK  = 29;
    localparam int D_UF  = 28;
    localparam int D_UOR = 16;
    localparam int D_GBS = 13;
    localparam int D_TF  = 12;
    localparam int D_TOR = 0;

    // Buffer status codes
    localparam logic [2:0] GBS_INIT   = 3'h0;
    localparam logic [2:0] GBS_NORMAL = 3'h1;
    localparam logic [2:0] GBS_BOUND  = 3'h2;
    localparam logic [2:0] GBS_OVWR   = 3'h3;
    localparam logic [2:0] GBS_PRESET = 3'h4;
    localparam logic [2:0] GBS_LOCKED = 3'h5;
    localparam logic [2:0] GBS_STALL  = 3'h6;
    localparam logic [2:0] GBS_OFF    = 3'h7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS    = 50;
    localparam int FRAME_NS  = 125000;
    localparam int FRAME_CYC = FRAME_NS / CLK_NS;

    typedef enum {ST_IDLE, ST_FETCH, ST_DATA, ST_UPDATE} vcxb_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [6:0]  len;
    } vcxb_pci_req_t;

    typedef struct packed {
        logic        beat;
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } vcxb_pci_rsp_t;
endpackage

// ==== verilog/vcxb_notify_queue.sv ====
// Notify queue of channel numbers with per-channel pending bits
`timescale 1ns/10ps
module vcxb_notify_queue
    import vcxb_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            reset_n_i,
    input  wire logic            push_i,
    input  wire logic [CH_W-1:0] push_ch_i,
    input  wire logic            pop_i,
    input  wire logic            clear_i,
    input  wire logic [CH_W-1:0] clear_ch_i,
    output logic                 head_valid_o,
    output logic [CH_W-1:0]      head_ch_o,
    output logic                 dup_o,
    output logic                 stale_o
);
    logic [CH_W-1:0] fifo [NUM_CH];
    logic [NUM_CH-1:0] pend;
    logic [CH_W-1:0]   wp;
    logic [CH_W-1:0]   rp;
    logic [CH_W:0]     cnt;
    logic [11:0]       age;

    // One entry per channel at most, so the queue can never overflow
    wire accept = push_i && !pend[push_ch_i];
    wire take   = pop_i && (cnt != '0);
    assign dup_o        = push_i && pend[push_ch_i];
    assign head_valid_o = (cnt != '0);
    assign head_ch_o    = fifo[rp];
    assign stale_o      = head_valid_o && (age == 12'(FRAME_CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (accept) begin
            fifo[wp] <= push_ch_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend <= '0;
            wp   <= '0;
            rp   <= '0;
            cnt  <= '0;
            age  <= 12'h000;
        end else begin
            wp  <= wp + CH_W'(accept);
            rp  <= rp + CH_W'(take);
            cnt <= cnt + (CH_W+1)'(accept) - (CH_W+1)'(take);
            // Set wins over a clear of the same channel
            if (clear_i) begin
                pend[clear_ch_i] <= 1'b0;
            end
            if (accept) begin
                pend[push_ch_i] <= 1'b1;
            end
            age <= (take || !head_valid_o || stale_o) ? 12'h000 : age + 12'h001;
        end
    end

    a_pend_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        accept |=> pend[$past(push_ch_i)]) else $error("pending bit not set on enqueue");
    a_pend_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (clear_i && !(push_i && push_ch_i == clear_ch_i)) |=> !pend[$past(clear_ch_i)])
        else $error("pending bit not cleared on completion");
endmodule

// ==== testbench/vcxb_pci_model.sv ====
// Behavioural PCI target with descriptor and buffer memory
`timescale 1ns/10ps
module vcxb_pci_model
    import vcxb_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          reset_n_i,
    input  wire vcxb_pci_req_t pci_req_i,
    input  wire logic [31:0]   pci_wdata_i,
    input  wire logic          fail_i,
    output vcxb_pci_rsp_t      pci_rsp_o
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] a;
    logic        hold;
    int          n;
    // Beats only every other cycle, so the engine must tolerate waits
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pci_rsp_o <= '0;
            hold <= 1'b0;
            n = 0;
        end else begin
            hold <= ~hold;
            pci_rsp_o <= '0;
            pci_rsp_o.rdata <= ~pci_rsp_o.rdata;
            a = pci_req_i.addr + 32'(4 * n);
            if (pci_req_i.valid && hold) begin
                pci_rsp_o.beat <= !fail_i;
                pci_rsp_o.err <= fail_i;
                pci_rsp_o.done <= !fail_i && n == int'(pci_req_i.len) - 1;
                if (pci_req_i.write)
                    mem[a] = pci_wdata_i;
                else
                    pci_rsp_o.rdata <= mem.exists(a) ? mem[a] : 32'h0;
                n = (fail_i || n == int'(pci_req_i.len) - 1) ? 0 : n + 1;
            end
        end
    end
endmodule

// ==== testbench/vcxb_engine_tb.sv ====
// Self-checking bench for the external buffer transfer engine
`timescale 1ns/10ps
module vcxb_engine_tb;
    import vcxb_pkg::*;
    logic          core_clk_i  = 1'b0;
    logic          reset_n_i   = 1'b0;
    logic [19:0]   reg_addr_i  = '0;
    logic [31:0]   reg_wdata_i = '0;
    logic          reg_wr_i    = 1'b0;
    logic          reg_rd_i    = 1'b0;
    logic          tdm_valid_i = 1'b0;
    logic [8:0]    tdm_ch_i    = '0;
    logic [31:0]   tdm_wdata_i = '0;
    logic          fail_i      = 1'b0;
    logic [31:0]   reg_rdata_o, tdm_rdata_o, pci_wdata_o, q0, q1;
    logic [7:0]    sys_err_o;
    vcxb_pci_req_t pci_req_o;
    vcxb_pci_rsp_t pci_rsp_i;
    vcxb_pci_req_t log_q [$];
    int            fail_count  = 0;
    int            comparisons = 0;
    always #25 core_clk_i = ~core_clk_i;
    vcxb_engine dut (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .tdm_valid_i, .tdm_ch_i, .tdm_wdata_i, .tdm_rdata_o,
        .pci_req_o, .pci_wdata_o, .pci_rsp_i, .sys_err_o);
    vcxb_pci_model pm (.core_clk_i, .reset_n_i, .pci_req_i(pci_req_o),
        .pci_wdata_i(pci_wdata_o), .fail_i, .pci_rsp_o(pci_rsp_i));
    // Each finished PCI request is logged once, at the edge that ends it
    always @(posedge core_clk_i) if (pci_rsp_i.done || pci_rsp_i.err) log_q.push_back(pci_req_o);
    task automatic end_of_test();
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_req(input logic w, input logic [31:0] a, input logic [6:0] l);
        vcxb_pci_req_t r;
        r = (log_q.size() > 0) ? log_q.pop_front() : '0;
        chk({24'h0, r.write, r.len}, {24'h0, w, l});
        chk(r.addr, a);
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk(reg_rdata_o, e);
        @(posedge core_clk_i);
    endtask
    task automatic tdm2(input logic [8:0] ch, input logic [31:0] d);
        tdm_ch_i <= ch;
        tdm_wdata_i <= d;
        tdm_valid_i <= 1'b1;
        @(posedge core_clk_i);
        tdm_wdata_i <= d + 32'h1;
        @(negedge core_clk_i);
        q0 = tdm_rdata_o;
        @(posedge core_clk_i);
        tdm_valid_i <= 1'b0;
        @(negedge core_clk_i);
        q1 = tdm_rdata_o;
        @(posedge core_clk_i);
    endtask
    task automatic wait_seq(input int k);
        int i;
        for (i = 0; i < 400 && log_q.size() < k; i++) @(posedge core_clk_i);
        if (i == 400) begin
            fail_count++;
            $display("wrong value at %0t: sequence timed out", $time);
            end_of_test();
        end
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic t_push();
        pm.mem[32'h128] = 32'h0000_1FF8;
        pm.mem[32'h12C] = 32'h0100_0000;
        wr(CH_SEL_OFS, 32'h5);
        wr(CH_CFG_OFS, 32'h9);
        tdm2(9'h5, 32'hA5A5_0000);
        wait_seq(3);
        chk_req(1'b0, 32'h128, 7'h02);
        chk_req(1'b1, 32'h1000, 7'h02);
        chk_req(1'b1, 32'h12C, 7'h01);
        chk(pm.mem[32'h1000], 32'hA5A5_0000);
        chk(pm.mem[32'h1004], 32'hA5A5_0001);
        chk(pm.mem[32'h12C], 32'h0100_2008);
        chk({24'h0, sys_err_o}, 32'h0);
    endtask
    task automatic t_lock();
        pm.mem[32'h12C] = 32'h6100_2008;
        tdm2(9'h5, 32'h0);
        wait_seq(2);
        chk_req(1'b0, 32'h128, 7'h02);
        chk_req(1'b1, 32'h12C, 7'h01);
        chk(pm.mem[32'h12C], 32'h6100_A008);
        wr(SYS_ERR_OFS, 32'hFF);
        rd(SYS_ERR_OFS, 32'h48);
        chk({24'h0, sys_err_o}, 32'h48);
        wr(ERR_CLR_OFS, 32'hFF);
        rd(SYS_ERR_OFS, 32'h0);
    endtask
    task automatic t_fail();
        pm.mem[32'h12C] = 32'h0100_2008;
        fail_i <= 1'b1;
        tdm2(9'h5, 32'h0);
        wait_seq(1);
        fail_i <= 1'b0;
        chk_req(1'b0, 32'h128, 7'h02);
        rd(SYS_ERR_OFS, 32'h80);
        wr(CH_SEL_OFS, 32'h7);
        wr(CH_CFG_OFS, 32'h4);
        rd(SYS_ERR_OFS, 32'h82);
        wr(ERR_CLR_OFS, 32'hFF);
    endtask
    task automatic t_pull();
        pm.mem[32'h130] = 32'h0000_2FF8;
        pm.mem[32'h134] = 32'h0010_0000;
        pm.mem[32'h2000] = 32'hCAFE_0001;
        pm.mem[32'h2004] = 32'hCAFE_0002;
        wr(CH_SEL_OFS, 32'h6);
        wr(CH_CFG_OFS, 32'h40B);
        tdm2(9'h6, 32'h0);
        wait_seq(3);
        chk_req(1'b0, 32'h130, 7'h02);
        chk_req(1'b0, 32'h2000, 7'h02);
        chk_req(1'b1, 32'h134, 7'h01);
        chk(pm.mem[32'h134], 32'h0010_2008);
        tdm2(9'h6, 32'h0);
        chk(q0, 32'hCAFE_0001);
        chk(q1, 32'hCAFE_0002);
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        rd(DESC_BASE_OFS, DESC_BASE_RST);
        rd(SYS_ERR_OFS, {24'h0, SYS_ERR_RST});
        rd(20'h00200, 32'h0);
        wr(DESC_BASE_OFS, 32'h0000_0100);
        t_push();
        t_lock();
        t_fail();
        t_pull();
        end_of_test();
    end
endmodule
